//--- shared/bit_branch_pkg.sv
// Constants, types and helpers shared by the bit-test branch unit.
// Assumes an upstream decoder resolves operand addresses and sources.
package bit_branch_pkg;

    localparam int DIV_SEL_W = 3;
    localparam int WAIT_W = 4;
    localparam int CNT_W = 6;
    localparam int LEN_W = 3;

    localparam int FLAG_GATE = 7;
    localparam int FLAG_ZERO = 6;
    localparam int FLAG_BANK1 = 5;
    localparam int FLAG_AUX = 4;
    localparam int FLAG_BANK0 = 3;
    localparam int FLAG_CARRY = 0;
    localparam logic [7:0] FLAGS_RST = 8'h02;

    localparam logic [LEN_W-1:0] LEN_1 = 3'h1;
    localparam logic [LEN_W-1:0] LEN_2 = 3'h2;
    localparam logic [LEN_W-1:0] LEN_3 = 3'h3;
    localparam logic [LEN_W-1:0] LEN_4 = 3'h4;

    localparam logic [CNT_W-1:0] CLK_2 = 6'h02;
    localparam logic [CNT_W-1:0] CLK_4 = 6'h04;
    localparam logic [CNT_W-1:0] CLK_6 = 6'h06;
    localparam logic [CNT_W-1:0] CLK_8 = 6'h08;
    localparam logic [CNT_W-1:0] CLK_9 = 6'h09;
    localparam logic [CNT_W-1:0] CLK_10 = 6'h0A;
    localparam logic [CNT_W-1:0] CLK_11 = 6'h0B;
    localparam logic [CNT_W-1:0] CLK_12 = 6'h0C;

    typedef enum logic [3:0] {
        OP_BIT_SET, OP_BIT_CLEAR, OP_SET_CLEAR, OP_DEC_BRANCH,
        OP_BANK_SEL, OP_IDLE, OP_IRQ_ON, OP_IRQ_OFF,
        OP_PAUSE, OP_DEEP_STOP
    } op_e;

    typedef enum logic [2:0] {
        SRC_SHORT_DIRECT, SRC_SPECIAL, SRC_ACC, SRC_FLAGS,
        SRC_POINTER, SRC_REG_B, SRC_REG_C, SRC_NONE
    } src_e;

    typedef struct packed {
        op_e op;
        src_e src;
        logic [2:0] bit_sel;
        logic [7:0] short_relative_offset;
        logic [15:0] pc;
        logic [15:0] addr;
        logic [7:0] reg_val;
        logic [1:0] bank;
        logic fast_ram;
        logic ext_area;
        logic rom_fetch;
    } instr_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic valid;
        src_e target;
        logic [7:0] value;
    } wb_s;

    function automatic logic is_mem(input src_e s);
        is_mem = (s == SRC_SHORT_DIRECT) || (s == SRC_SPECIAL) ||
            (s == SRC_POINTER);
    endfunction : is_mem

endpackage : bit_branch_pkg

//--- logic/cpu_tick_gen.sv
// CPU clock tick generator: one pulse per selected CPU clock period.
// Assumes the select input is static while an instruction runs.
`timescale 1ns/1ps
`default_nettype none
module cpu_tick_gen #(
    parameter int SEL_W = 3
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [SEL_W-1:0] sel_i,
    output var logic tick_o
);
    localparam int DCNT_W = (1 << SEL_W) - 1;

    logic [DCNT_W-1:0] cnt_reg;
    logic [DCNT_W-1:0] limit;

    assign limit = (DCNT_W'(1) << sel_i) - DCNT_W'(1);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end
        else if (cnt_reg >= limit)
        begin
            cnt_reg <= '0;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + DCNT_W'(1);
            tick_o <= 1'b0;
        end
    end
endmodule : cpu_tick_gen
`default_nettype wire

//--- logic/exec_timing.sv
// Length and clock-count lookup for one decoded instruction.
// Assumes fast_ram is low for special-space and external operands.
`timescale 1ns/1ps
`default_nettype none
module exec_timing (
    input wire bit_branch_pkg::instr_s instr_i,
    input wire logic [bit_branch_pkg::WAIT_W-1:0] rd_waits_i,
    input wire logic [bit_branch_pkg::WAIT_W-1:0] wr_waits_i,
    output var logic [bit_branch_pkg::LEN_W-1:0] bytes_o,
    output var logic [bit_branch_pkg::CNT_W-1:0] clocks_o
);
    import bit_branch_pkg::*;

    logic slow;
    logic [CNT_W-1:0] n_w;
    logic [CNT_W-1:0] m_w;

    // Second column whenever the data lies outside fast RAM.
    assign slow = is_mem(instr_i.src) ? !instr_i.fast_ram :
        (instr_i.src == SRC_FLAGS);
    assign n_w = instr_i.ext_area ? CNT_W'(rd_waits_i) : '0;
    assign m_w = instr_i.ext_area ? CNT_W'(wr_waits_i) : '0;

    always_comb
    begin
        bytes_o = LEN_1;
        clocks_o = CLK_2;
        unique case (instr_i.op)
            OP_BIT_SET, OP_BIT_CLEAR, OP_SET_CLEAR:
            begin
                unique case (instr_i.src)
                    SRC_SPECIAL:
                    begin
                        bytes_o = LEN_4;
                        clocks_o = (instr_i.op == OP_SET_CLEAR) ?
                            CLK_12 : CLK_11;
                    end
                    SRC_ACC:
                    begin
                        bytes_o = LEN_3;
                        clocks_o = CLK_8;
                    end
                    SRC_FLAGS:
                    begin
                        bytes_o = (instr_i.op == OP_BIT_SET) ? LEN_3 : LEN_4;
                        clocks_o = (instr_i.op == OP_BIT_SET) ? CLK_9 :
                            (instr_i.op == OP_BIT_CLEAR) ? CLK_11 : CLK_12;
                    end
                    SRC_POINTER:
                    begin
                        bytes_o = LEN_3;
                        if (!slow)
                            clocks_o = CLK_10;
                        else if (instr_i.op == OP_SET_CLEAR)
                            clocks_o = CLK_12 + n_w + m_w;
                        else
                            clocks_o = CLK_11 + n_w;
                    end
                    default:
                    begin
                        unique case (instr_i.op)
                            OP_BIT_SET:
                            begin
                                bytes_o = LEN_3;
                                clocks_o = slow ? CLK_9 : CLK_8;
                            end
                            OP_BIT_CLEAR:
                            begin
                                bytes_o = LEN_4;
                                clocks_o = slow ? CLK_11 : CLK_10;
                            end
                            default:
                            begin
                                bytes_o = LEN_4;
                                clocks_o = slow ? CLK_12 : CLK_10;
                            end
                        endcase
                    end
                endcase
            end
            OP_DEC_BRANCH:
            begin
                if (is_mem(instr_i.src))
                begin
                    bytes_o = LEN_3;
                    clocks_o = slow ? CLK_10 : CLK_8;
                end
                else
                begin
                    bytes_o = LEN_2;
                    clocks_o = CLK_6;
                end
            end
            OP_BANK_SEL:
            begin
                bytes_o = LEN_2;
                clocks_o = CLK_4;
            end
            OP_IDLE:
            begin
                bytes_o = LEN_1;
                clocks_o = CLK_2;
            end
            OP_IRQ_ON, OP_IRQ_OFF, OP_PAUSE, OP_DEEP_STOP:
            begin
                bytes_o = LEN_2;
                clocks_o = CLK_6;
            end
            default:
            begin
                bytes_o = LEN_1;
                clocks_o = CLK_2;
            end
        endcase
    end
endmodule : exec_timing
`default_nettype wire

//--- logic/bit_branch_exec.sv
// Execution unit for bit-test branches, loop decrements and CPU control.
// Assumes a decoder hands over one resolved instruction at a time and
// that memory returns read data within one CPU clock of the request.
`timescale 1ns/1ps
`default_nettype none
module bit_branch_exec (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [bit_branch_pkg::DIV_SEL_W-1:0] cpu_div_sel_i,
    input wire logic [bit_branch_pkg::WAIT_W-1:0] rd_waits_i,
    input wire logic [bit_branch_pkg::WAIT_W-1:0] wr_waits_i,
    input wire logic instr_valid_i,
    input wire bit_branch_pkg::instr_s instr_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic wake_i,
    output var logic ready_o,
    output var logic done_o,
    output var logic taken_o,
    output var logic [15:0] pc_o,
    output var bit_branch_pkg::mem_req_s mem_o,
    output var bit_branch_pkg::wb_s wb_o,
    output var logic [7:0] flags_o,
    output var logic master_irq_gate_o,
    output var logic [1:0] bank_pointer_bits_o,
    output var logic [1:0] standby_o,
    output var logic timing_exact_o
);
    import bit_branch_pkg::*;

    logic tick;
    logic [LEN_W-1:0] len_now;
    logic [CNT_W-1:0] clk_now;

    instr_s cur_reg;
    logic busy_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] total_reg;
    logic [LEN_W-1:0] len_reg;
    logic [7:0] opnd_reg;

    logic issue;
    logic last;
    logic busy_next;
    logic [1:0] standby_next;

    logic [7:0] operand;
    logic bit_val;
    logic take;
    logic wr_back;
    logic [7:0] new_val;
    logic [15:0] next_pc;
    logic [15:0] target;

    cpu_tick_gen #(
        .SEL_W(DIV_SEL_W)
    ) u_tick (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sel_i(cpu_div_sel_i),
        .tick_o(tick)
    );

    exec_timing u_timing (
        .instr_i(instr_i),
        .rd_waits_i(rd_waits_i),
        .wr_waits_i(wr_waits_i),
        .bytes_o(len_now),
        .clocks_o(clk_now)
    );

    assign issue = instr_valid_i && ready_o;
    // The count runs in CPU clocks, so a slower divider stretches it.
    assign last = busy_reg && tick &&
        (cnt_reg == total_reg - CNT_W'(1));
    assign busy_next = issue || (busy_reg && !last);

    always_comb
    begin
        standby_next = standby_o;
        if (wake_i)
            standby_next = 2'h0;
        // A standby request finishing with a wake still enters standby.
        if (last && cur_reg.op == OP_PAUSE)
            standby_next = 2'h1;
        if (last && cur_reg.op == OP_DEEP_STOP)
            standby_next = 2'h2;
    end

    // Instruction capture and clock counting.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cur_reg <= '0;
            busy_reg <= 1'b0;
            cnt_reg <= '0;
            total_reg <= '0;
            len_reg <= '0;
            ready_o <= 1'b0;
            timing_exact_o <= 1'b1;
        end
        else
        begin
            busy_reg <= busy_next;
            ready_o <= !busy_next && (standby_next == 2'h0);
            if (issue)
            begin
                cur_reg <= instr_i;
                cnt_reg <= '0;
                total_reg <= clk_now;
                len_reg <= len_now;
                // Counts only hold for code fetched from internal ROM.
                timing_exact_o <= instr_i.rom_fetch;
            end
            else if (busy_reg && tick)
            begin
                cnt_reg <= cnt_reg + CNT_W'(1);
            end
        end
    end

    // Operand capture: registers at issue, memory one CPU clock after
    // the read request.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            opnd_reg <= '0;
        end
        else if (issue)
        begin
            opnd_reg <= instr_i.reg_val;
        end
        else if (busy_reg && tick && cnt_reg == CNT_W'(1) &&
            is_mem(cur_reg.src))
        begin
            opnd_reg <= mem_rdata_i;
        end
    end

    assign operand = (cur_reg.src == SRC_FLAGS) ? flags_o : opnd_reg;
    assign bit_val = operand[cur_reg.bit_sel];

    always_comb
    begin
        take = 1'b0;
        wr_back = 1'b0;
        new_val = operand;
        unique case (cur_reg.op)
            OP_BIT_SET:
            begin
                take = bit_val;
            end
            OP_BIT_CLEAR:
            begin
                take = !bit_val;
            end
            OP_SET_CLEAR:
            begin
                take = bit_val;
                wr_back = bit_val;
                new_val = operand & ~(8'h01 << cur_reg.bit_sel);
            end
            OP_DEC_BRANCH:
            begin
                new_val = operand - 8'h01;
                wr_back = 1'b1;
                take = (new_val != 8'h00);
            end
            default:
            begin
                take = 1'b0;
                wr_back = 1'b0;
                new_val = operand;
            end
        endcase
    end

    assign next_pc = cur_reg.pc + 16'(len_reg);
    // The offset is sign-extended and counted from the next instruction.
    assign target = next_pc +
        {{8{cur_reg.short_relative_offset[7]}},
        cur_reg.short_relative_offset};

    // Completion: program counter, done and taken indications.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pc_o <= '0;
            done_o <= 1'b0;
            taken_o <= 1'b0;
        end
        else
        begin
            done_o <= last;
            taken_o <= last && take;
            if (last)
                pc_o <= take ? target : next_pc;
        end
    end

    // Memory port: a read at the first CPU clock, a write at the end.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mem_o <= '0;
        end
        else
        begin
            mem_o.rd <= busy_reg && tick && cnt_reg == '0 &&
                is_mem(cur_reg.src);
            mem_o.wr <= last && wr_back && is_mem(cur_reg.src);
            if (busy_reg)
                mem_o.addr <= cur_reg.addr;
            if (last)
                mem_o.wdata <= new_val;
        end
    end

    // Register write-back for accumulator, B and C.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wb_o <= '0;
        end
        else
        begin
            wb_o.valid <= last && wr_back &&
                (cur_reg.src == SRC_ACC || cur_reg.src == SRC_REG_B ||
                cur_reg.src == SRC_REG_C);
            if (last)
            begin
                wb_o.target <= cur_reg.src;
                wb_o.value <= new_val;
            end
        end
    end

    // Flags word, holding the master gate and the bank bits.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flags_o <= FLAGS_RST;
        end
        else if (last)
        begin
            unique case (cur_reg.op)
                OP_SET_CLEAR:
                begin
                    // Clearing a flags bit may hit any bit, the gate and bank bits included.
                    if (wr_back && cur_reg.src == SRC_FLAGS)
                        flags_o <= new_val;
                end
                OP_IRQ_ON:
                begin
                    flags_o[FLAG_GATE] <= 1'b1;
                end
                OP_IRQ_OFF:
                begin
                    flags_o[FLAG_GATE] <= 1'b0;
                end
                OP_BANK_SEL:
                begin
                    flags_o[FLAG_BANK1] <= cur_reg.bank[1];
                    flags_o[FLAG_BANK0] <= cur_reg.bank[0];
                end
                default:
                begin
                    flags_o <= flags_o;
                end
            endcase
        end
    end

    assign master_irq_gate_o = flags_o[FLAG_GATE];
    assign bank_pointer_bits_o = {flags_o[FLAG_BANK1], flags_o[FLAG_BANK0]};

    // Standby state: bit 0 pause, bit 1 deep stop; wake clears both.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            standby_o <= 2'h0;
        end
        else
        begin
            standby_o <= standby_next;
        end
    end

endmodule : bit_branch_exec
`default_nettype wire

//--- test/mem_model.sv
// Behavioural data memory on the far side of the execution unit.
// Assumes one read or write request at a time from the unit.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input wire logic clk_i,
    input wire bit_branch_pkg::mem_req_s req_i,
    output var logic [7:0] rdata_o
);
    import bit_branch_pkg::*;
    logic [7:0] mem [256];
    logic [7:0] addr_reg = 8'h00;
    logic hold_reg = 1'h0;
    // Each byte starts equal to its own address so the bench can predict it.
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0];
    end
    always @(posedge clk_i)
    begin
        hold_reg <= req_i.rd;
        if (req_i.rd)
            addr_reg <= req_i.addr[7:0];
        if (req_i.wr)
            mem[req_i.addr[7:0]] <= req_i.wdata;
    end
    // Data stands during the read and one clock after; then it is inverted
    // so that a late sample can never pass for a good one.
    always_comb
    begin
        if (req_i.rd)
            rdata_o = mem[req_i.addr[7:0]];
        else if (hold_reg)
            rdata_o = mem[addr_reg];
        else
            rdata_o = ~mem[addr_reg];
    end
endmodule : mem_model
`default_nettype wire

//--- test/bit_branch_exec_chk.sv
// Concurrent checks on the ports of bit_branch_exec.
// Assumes one clock clk_i and the active-low reset rst_n_i.
`timescale 1ns/1ps
`default_nettype none
module bit_branch_exec_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [bit_branch_pkg::DIV_SEL_W-1:0] cpu_div_sel_i,
    input wire logic instr_valid_i,
    input wire bit_branch_pkg::instr_s instr_i,
    input wire logic wake_i,
    input wire logic ready_o,
    input wire logic done_o,
    input wire logic taken_o,
    input wire bit_branch_pkg::mem_req_s mem_o,
    input wire bit_branch_pkg::wb_s wb_o,
    input wire logic [7:0] flags_o,
    input wire logic master_irq_gate_o,
    input wire logic [1:0] bank_pointer_bits_o,
    input wire logic [1:0] standby_o,
    input wire logic timing_exact_o
);
    import bit_branch_pkg::*;
    wire logic issue = ready_o && instr_valid_i;
    wire logic div1 = cpu_div_sel_i == 3'h0;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_taken_done: assert property (taken_o |-> done_o)
        else $error("taken pulse without done");
    a_write_done: assert property (mem_o.wr |-> done_o)
        else $error("write not at completion");
    a_read_pulse: assert property (mem_o.rd |=> !mem_o.rd)
        else $error("read request longer than one clock");
    a_issue_busy: assert property (issue |=> !ready_o && !done_o)
        else $error("unit ready right after issue");
    a_acc_time: assert property (issue && div1 &&
        instr_i.src == SRC_ACC |=> !done_o [*8] ##1 done_o)
        else $error("accumulator branch not 8 clocks");
    a_irq_on: assert property (issue && div1 &&
        instr_i.op == OP_IRQ_ON |=> !done_o [*6] ##1
        (done_o && master_irq_gate_o))
        else $error("gate not set after 6 clocks");
    a_irq_off: assert property (issue && div1 &&
        instr_i.op == OP_IRQ_OFF |=> ##6 (done_o && !master_irq_gate_o))
        else $error("gate not cleared after 6 clocks");
    a_idle_time: assert property (issue && div1 &&
        instr_i.op == OP_IDLE |=> !done_o [*2] ##1 done_o)
        else $error("idle op not 2 clocks");
    a_gate_hold: assert property (!done_o |->
        $stable(master_irq_gate_o))
        else $error("gate moved early");
    a_bank_hold: assert property (!done_o |->
        $stable(bank_pointer_bits_o))
        else $error("bank bits moved early");
    a_standby_stall: assert property
        (standby_o != 2'h0 && !wake_i |=> !ready_o)
        else $error("ready while in standby");
    a_exact_follow: assert property (issue |=>
        timing_exact_o == $past(instr_i.rom_fetch))
        else $error("timing flag not from last issue");
endmodule : bit_branch_exec_chk
bind bit_branch_exec bit_branch_exec_chk u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_div_sel_i(cpu_div_sel_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .wake_i(wake_i),
    .ready_o(ready_o), .done_o(done_o), .taken_o(taken_o),
    .mem_o(mem_o), .wb_o(wb_o), .flags_o(flags_o),
    .master_irq_gate_o(master_irq_gate_o),
    .bank_pointer_bits_o(bank_pointer_bits_o), .standby_o(standby_o),
    .timing_exact_o(timing_exact_o)
);
`default_nettype wire

//--- test/bit_branch_exec_tb.sv
// Bench for bit_branch_exec: timing, branch target and side effects.
// Assumes mem_model, whose byte at address a starts as a.
`timescale 1ns/1ps
`default_nettype none
module bit_branch_exec_tb;
    import bit_branch_pkg::*;
    localparam src_e SD = SRC_SHORT_DIRECT;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic [2:0] cpu_div_sel_i = 3'h0;
    logic [3:0] rd_waits_i = 4'h0;
    logic [3:0] wr_waits_i = 4'h0;
    logic instr_valid_i = 1'h0;
    instr_s instr_i = '0;
    logic wake_i = 1'h0;
    logic [7:0] mem_rdata_i;
    logic ready_o;
    logic done_o;
    logic taken_o;
    logic [15:0] pc_o;
    mem_req_s mem_o;
    wb_s wb_o;
    logic [7:0] flags_o;
    logic master_irq_gate_o;
    logic [1:0] bank_pointer_bits_o;
    logic [1:0] standby_o;
    logic timing_exact_o;
    int errors = 0;
    int cmp_count = 0;
    int tests = 0;
    logic [15:0] cnt;
    logic [7:0] off = 8'hF0;
    logic fast = 1'h1;
    logic ext = 1'h0;
    logic rom = 1'h1;
    logic [2:0] sel = 3'h0;
    logic [3:0] nw = 4'h0;
    logic [3:0] mw = 4'h0;
    bit_branch_exec u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .cpu_div_sel_i(cpu_div_sel_i), .rd_waits_i(rd_waits_i),
        .wr_waits_i(wr_waits_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .mem_rdata_i(mem_rdata_i), .wake_i(wake_i),
        .ready_o(ready_o), .done_o(done_o), .taken_o(taken_o),
        .pc_o(pc_o), .mem_o(mem_o), .wb_o(wb_o), .flags_o(flags_o),
        .master_irq_gate_o(master_irq_gate_o),
        .bank_pointer_bits_o(bank_pointer_bits_o),
        .standby_o(standby_o), .timing_exact_o(timing_exact_o));
    mem_model u_mem (.clk_i(clk_i), .req_i(mem_o), .rdata_o(mem_rdata_i));
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic fin;
        tests++;
        $display("test %0d done", tests);
    endtask : fin
    function automatic instr_s mk(op_e o, src_e s, logic [2:0] b,
        logic [7:0] a);
        mk = '0;
        mk.op = o;
        mk.src = s;
        mk.bit_sel = b;
        mk.short_relative_offset = off;
        mk.pc = 16'h4000;
        mk.addr = {8'h00, a};
        mk.reg_val = a;
        mk.bank = b[1:0];
        mk.fast_ram = fast;
        mk.ext_area = ext;
        mk.rom_fetch = rom;
    endfunction : mk
    // Issue one instruction, count clocks to completion, check the new PC.
    task automatic run(input instr_s i, input int k, input logic tk,
        input logic [15:0] len);
        @(posedge clk_i);
        instr_valid_i <= 1'h1;
        instr_i <= i;
        cpu_div_sel_i <= sel;
        rd_waits_i <= nw;
        wr_waits_i <= mw;
        @(posedge clk_i);
        instr_valid_i <= 1'h0;
        #1;
        cnt = 16'h0000;
        while (done_o !== 1'h1 && cnt < 16'h0050)
        begin
            @(posedge clk_i);
            #1;
            cnt = cnt + 16'h0001;
        end
        if (k > 0)
            check(cnt, k[15:0]);
        check({15'h0000, taken_o}, {15'h0000, tk});
        check(pc_o, 16'h4000 + len + (tk ? {{8{off[7]}}, off} : '0));
    endtask : run
    task automatic t_flags;
        check(flags_o, 8'h02);
        run(mk(OP_BIT_SET, SRC_FLAGS, 3'h1, 8'h00), 9, 1'h1, 3);
        run(mk(OP_BIT_CLEAR, SRC_FLAGS, 3'h1, 8'h00), 11, 1'h0, 4);
        run(mk(OP_SET_CLEAR, SRC_FLAGS, 3'h1, 8'h00), 12, 1'h1, 4);
        check(flags_o, 8'h00);
        run(mk(OP_BIT_CLEAR, SRC_FLAGS, 3'h1, 8'h00), 11, 1'h1, 4);
        fin();
    endtask : t_flags
    task automatic t_short;
        run(mk(OP_BIT_SET, SD, 3'h0, 8'h05), 8, 1'h1, 3);
        off = 8'h7F;
        run(mk(OP_BIT_CLEAR, SD, 3'h0, 8'h04), 10, 1'h1, 4);
        fast = 1'h0;
        run(mk(OP_BIT_CLEAR, SD, 3'h0, 8'h05), 11, 1'h0, 4);
        run(mk(OP_BIT_SET, SD, 3'h0, 8'h04), 9, 1'h0, 3);
        off = 8'hF0;
        fin();
    endtask : t_short
    task automatic t_spec_acc;
        run(mk(OP_BIT_SET, SRC_SPECIAL, 3'h1, 8'h02), 11, 1'h1, 4);
        run(mk(OP_BIT_CLEAR, SRC_SPECIAL, 3'h1, 8'h02), 11, 1'h0, 4);
        run(mk(OP_SET_CLEAR, SRC_SPECIAL, 3'h1, 8'h02), 12, 1'h1, 4);
        check({mem_o.wr, mem_o.wdata}, 9'h100);
        run(mk(OP_BIT_SET, SRC_ACC, 3'h7, 8'h80), 8, 1'h1, 3);
        run(mk(OP_BIT_CLEAR, SRC_ACC, 3'h7, 8'h80), 8, 1'h0, 3);
        run(mk(OP_SET_CLEAR, SRC_ACC, 3'h7, 8'h80), 8, 1'h1, 3);
        check({wb_o.valid, wb_o.value}, 9'h100);
        fin();
    endtask : t_spec_acc
    task automatic t_clear;
        fast = 1'h1;
        run(mk(OP_SET_CLEAR, SD, 3'h3, 8'h0F), 10, 1'h1, 4);
        check({mem_o.wr, mem_o.wdata}, 9'h107);
        fast = 1'h0;
        run(mk(OP_SET_CLEAR, SD, 3'h4, 8'h1F), 12, 1'h1, 4);
        check({mem_o.wr, mem_o.wdata}, 9'h10F);
        ext = 1'h1;
        nw = 4'h2;
        mw = 4'h5;
        run(mk(OP_SET_CLEAR, SRC_POINTER, 3'h5, 8'h21), 19, 1'h1, 3);
        check({mem_o.wr, mem_o.wdata}, 9'h101);
        fin();
    endtask : t_clear
    task automatic t_pointer;
        nw = 4'h3;
        run(mk(OP_BIT_CLEAR, SRC_POINTER, 3'h1, 8'h01), 14, 1'h1, 3);
        run(mk(OP_BIT_SET, SRC_POINTER, 3'h0, 8'h01), 14, 1'h1, 3);
        ext = 1'h0;
        fast = 1'h1;
        run(mk(OP_BIT_SET, SRC_POINTER, 3'h0, 8'h01), 10, 1'h1, 3);
        run(mk(OP_BIT_CLEAR, SRC_POINTER, 3'h0, 8'h01), 10, 1'h0, 3);
        fin();
    endtask : t_pointer
    task automatic t_loop;
        run(mk(OP_DEC_BRANCH, SRC_REG_B, 3'h0, 8'h01), 6, 1'h0, 2);
        check({wb_o.valid, wb_o.value}, 9'h100);
        run(mk(OP_DEC_BRANCH, SRC_REG_C, 3'h0, 8'h00), 6, 1'h1, 2);
        check({wb_o.target, wb_o.valid, wb_o.value},
            {SRC_REG_C, 9'h1FF});
        run(mk(OP_DEC_BRANCH, SD, 3'h0, 8'h30), 8, 1'h1, 3);
        check({mem_o.wr, mem_o.wdata}, 9'h12F);
        fast = 1'h0;
        run(mk(OP_DEC_BRANCH, SD, 3'h0, 8'h01), 10, 1'h0, 3);
        check({mem_o.wr, mem_o.wdata}, 9'h100);
        fast = 1'h1;
        fin();
    endtask : t_loop
    // Standby must hold off new work until wake is raised.
    task automatic sleep(input op_e o, input logic [1:0] code);
        run(mk(o, SRC_NONE, 3'h0, 8'h00), 6, 1'h0, 2);
        repeat (3) @(posedge clk_i);
        #1;
        check({ready_o, standby_o}, {1'h0, code});
        @(posedge clk_i);
        wake_i <= 1'h1;
        @(posedge clk_i);
        wake_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        #1;
        check({ready_o, standby_o}, 3'h4);
    endtask : sleep
    task automatic t_ctrl;
        run(mk(OP_IRQ_ON, SRC_NONE, 3'h0, 8'h00), 6, 1'h0, 2);
        check(master_irq_gate_o, 1'h1);
        run(mk(OP_IRQ_OFF, SRC_NONE, 3'h0, 8'h00), 6, 1'h0, 2);
        check(master_irq_gate_o, 1'h0);
        run(mk(OP_BANK_SEL, SRC_NONE, 3'h2, 8'h00), 4, 1'h0, 2);
        check(bank_pointer_bits_o, 2'h2);
        run(mk(OP_IDLE, SRC_NONE, 3'h0, 8'h00), 2, 1'h0, 1);
        sleep(OP_PAUSE, 2'h1);
        sleep(OP_DEEP_STOP, 2'h2);
        fin();
    endtask : t_ctrl
    task automatic t_clock;
        rom = 1'h0;
        run(mk(OP_IDLE, SRC_NONE, 3'h0, 8'h00), 2, 1'h0, 1);
        check(timing_exact_o, 1'h0);
        rom = 1'h1;
        sel = 3'h1;
        run(mk(OP_IRQ_ON, SRC_NONE, 3'h0, 8'h00), 0, 1'h0, 2);
        check(cnt >= 16'hC && cnt <= 16'hE, 1'h1);
        sel = 3'h0;
        run(mk(OP_IDLE, SRC_NONE, 3'h0, 8'h00), 2, 1'h0, 1);
        check(timing_exact_o, 1'h1);
        fin();
    endtask : t_clock
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // The whole run needs well under 2000 clocks; this leaves ample slack.
    initial
    begin
        #50000;
        errors++;
        $display("[FAIL] %0t run did not finish", $time);
        summarize();
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        #1;
        t_flags();
        t_short();
        t_spec_acc();
        t_clear();
        t_pointer();
        t_loop();
        t_ctrl();
        t_clock();
        summarize();
    end
endmodule : bit_branch_exec_tb
`default_nettype wire
